// ---- hw/sdram_open_row_and_refresh_ctrl.v ----
// sdram open-row access and refresh sequencer with a wishbone register slave
// assumes single-beat memory requests from logic on clk_i and one sdram rank
// What this block does
// - a cache-disabled write that fits the bus is one single-beat write
// - keep-row-open bit set means read and write without auto-precharge
// - open rows stay open; a row hit issues read or write directly
// - a row miss precharges, waits precharge wait, activates, then accesses
// - after auto-precharge write, bank idle for write recovery plus precharge wait
// - row-hit read with latency one gets one no-operation cycle first
// - all banks count as closed after refresh and after bus release
// - refresh enable alone gives auto-refresh; with mode select, self-refresh
// - counter equal to compare raises request, bursts refreshes, clears counter
// - the counter counts on from its present value once clocked
// - each refresh: precharge-all, wait, refresh, then recovery idle
// - idle cycles between precharge-all and refresh only when wait is nonzero
// - self-refresh entry: precharge-all, wait, self command, no accesses
// - clearing mode select leaves self-refresh, then recovery idle
// - after self-refresh exit, auto-refresh resumes when enabled
// - self-refresh survives manual reset; power-on reset ends it
// - a refresh request waits for the running access to finish
// - a newer refresh request replaces a pending one
//
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "sdram_ctrl_defs.vh"
module sdram_open_row_and_refresh_ctrl (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        manual_rst_i,
   // wishbone slave
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [5:0]  adr_i,
   input  wire [3:0]  sel_i,
   input  wire [31:0] dat_i,
   output reg  [31:0] dat_o,
   output reg         ack_o,
   // memory request side
   input  wire        req_i,
   input  wire        req_we_i,
   input  wire [1:0]  req_bank_i,
   input  wire [12:0] req_row_i,
   input  wire [9:0]  req_col_i,
   input  wire [31:0] req_wdata_i,
   input  wire [3:0]  req_be_i,
   input  wire        bus_released_i,
   output wire        req_ready_o,
   output reg         req_done_o,
   // sdram pins
   output reg  [3:0]  cmd_o,
   output reg         cke_o,
   output reg  [1:0]  ba_o,
   output reg  [12:0] a_o,
   output reg  [3:0]  dqm_o,
   output reg  [31:0] dq_o,
   output reg         dq_oe_n_o
);
   localparam S_IDLE = 4'h0, S_PRE = 4'h1, S_PWAIT = 4'h2, S_ACT = 4'h3;
   localparam S_NOP = 4'h4, S_ACC = 4'h5, S_RECOV = 4'h6, S_PALL = 4'h7;
   localparam S_RWAIT = 4'h8, S_REF = 4'h9, S_SELF = 4'hA, S_SWAIT = 4'hB;
   localparam S_SREF = 4'hC, S_XWAIT = 4'hD;

   reg [2:0]  ctrl_q;
   reg [7:0]  wait_q;
   reg [5:0]  rtctl_q;
   reg [7:0]  rcomp_q;
   reg [3:0]  state_q;
   reg [7:0]  cnt_q;
   reg [2:0]  burst_q;
   reg        pend_q;
   reg        lost_q;
   reg        self_q;
   reg        done_self_q;
   reg [3:0]  open_q;
   reg [12:0] row_q [0:`BANKS-1];
   reg        wr_q;
   reg [1:0]  bank_q;
   reg [12:0] rrow_q;
   reg [9:0]  col_q;
   reg [31:0] wd_q;
   reg [3:0]  be_q;
   reg        act_q;
   reg [1:0]  mrst_sync_q;
   wire [7:0] rcount;
   wire       match;
   wire       wb_req = cyc_i & stb_i & ~ack_o;
   wire       wb_wr  = wb_req & we_i;
   wire [3:0] reg_sel = adr_i[`ADR_HI:`ADR_LO];
   wire       keep   = ctrl_q[`CTRL_KEEP_ROW];
   wire       ren    = ctrl_q[`CTRL_REFRESH_ENABLE_EN];
   wire       refresh_mode_select  = ctrl_q[`CTRL_REFRESH_MODE_SELECT];
   wire [1:0] cl     = wait_q[`WAIT_CL_HI:`WAIT_CL_LO];
   wire [7:0] trp    = {6'h00, wait_q[`WAIT_TRP_HI:`WAIT_TRP_LO]};
   wire [7:0] trc    = {6'h00, wait_q[`WAIT_TRC_HI:`WAIT_TRC_LO]};
   wire [7:0] twr    = {6'h00, wait_q[`WAIT_TWR_HI:`WAIT_TWR_LO]};
   integer i;

   // write merge of a byte-enabled bus word into a narrow register
   function [7:0] wb_byte0;
      input [7:0] old;
      input [31:0] d;
      input [3:0] s;
      begin
         wb_byte0 = s[0] ? d[7:0] : old;
      end
   endfunction

   wire [7:0] ctrl_merge  = wb_byte0({5'h00, ctrl_q}, dat_i, sel_i);
   wire [7:0] rtctl_merge = wb_byte0({2'h0, rtctl_q}, dat_i, sel_i);

   // ==========================================================
   // register slave, single-cycle ack
   always @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q  <= `CTRL_RESET;
         wait_q  <= `WAIT_RESET;
         rtctl_q <= 6'h00;
         rcomp_q <= `ZERO8;
         ack_o   <= 1'b0;
         dat_o   <= `ZERO32;
      end else begin
         ack_o <= wb_req;
         if (wb_wr) begin
            case (reg_sel)
               `ADR_CTRL:  ctrl_q  <= ctrl_merge[2:0];
               `ADR_WAIT:  wait_q  <= wb_byte0(wait_q, dat_i, sel_i);
               `ADR_RTCTL: rtctl_q <= rtctl_merge[5:0];
               `ADR_RCOMP: rcomp_q <= wb_byte0(rcomp_q, dat_i, sel_i);
               default:    ;
            endcase
         end
         if (wb_req && !we_i) begin
            case (reg_sel)
               `ADR_CTRL:   dat_o <= {29'h0, ctrl_q};
               `ADR_WAIT:   dat_o <= {24'h0, wait_q};
               `ADR_RTCTL:  dat_o <= {26'h0, rtctl_q};
               `ADR_RCOUNT: dat_o <= {24'h0, rcount};
               `ADR_RCOMP:  dat_o <= {24'h0, rcomp_q};
               `ADR_STATUS: dat_o <= {23'h0, lost_q, open_q, state_q};
               default:     dat_o <= `ZERO32;
            endcase
         end
      end
   end

   refresh_timer u_timer (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .cks_i      (rtctl_q[`RT_CKS_HI:`RT_CKS_LO]),
      .load_i     (wb_wr && reg_sel == `ADR_RCOUNT && sel_i[0]),
      .load_val_i (dat_i[7:0]),
      .compare_i  (rcomp_q),
      .count_o    (rcount),
      .match_o    (match)
   );

   assign req_ready_o = (state_q == S_IDLE) && !pend_q && !(ren && refresh_mode_select);

   // manual reset pin: two flops before any logic reads it
   always @(posedge clk_i) begin
      mrst_sync_q <= {mrst_sync_q[0], manual_rst_i};
   end

   // ==========================================================
   // sequencer
   always @(posedge clk_i) begin
      if (rst_i) begin
         state_q     <= S_IDLE;
         cnt_q       <= `ZERO8;
         burst_q     <= 3'h0;
         pend_q      <= 1'b0;
         lost_q      <= 1'b0;
         self_q      <= 1'b0;
         done_self_q <= 1'b0;
         open_q      <= 4'h0;
         wr_q        <= 1'b0;
         bank_q      <= 2'h0;
         rrow_q      <= 13'h0000;
         col_q       <= 10'h000;
         wd_q        <= `ZERO32;
         be_q        <= 4'hF;
         act_q       <= 1'b0;
         req_done_o  <= 1'b0;
         cmd_o       <= `CMD_DESEL;
         cke_o       <= 1'b1;
         ba_o        <= 2'h0;
         a_o         <= 13'h0000;
         dqm_o       <= 4'hF;
         dq_o        <= `ZERO32;
         dq_oe_n_o   <= 1'b1;
         for (i = 0; i < `BANKS; i = i + 1)
            row_q[i] <= 13'h0000;
      end else if (mrst_sync_q[1] && self_q) begin
         // self-refresh holds through a manual reset
         cmd_o      <= `CMD_DESEL;
         req_done_o <= 1'b0;
      end else begin
         cmd_o      <= `CMD_NOP;
         dq_oe_n_o  <= 1'b1;
         req_done_o <= 1'b0;
         if (bus_released_i)
            open_q <= 4'h0;
         if (match) begin
            if (pend_q)
               lost_q <= 1'b1;
            pend_q  <= ren && !refresh_mode_select;
            burst_q <= rtctl_q[`RT_RRC_HI:`RT_RRC_LO];
         end
         case (state_q)
            S_IDLE: begin
               if (ren && refresh_mode_select && !self_q) begin
                  cmd_o   <= `CMD_PRE;
                  a_o     <= 13'h0400;
                  open_q  <= 4'h0;
                  cnt_q   <= trp;
                  state_q <= S_SWAIT;
               end else if (pend_q) begin
                  state_q <= S_PALL;
               end else if (req_i) begin
                  wr_q   <= req_we_i;
                  bank_q <= req_bank_i;
                  rrow_q <= req_row_i;
                  col_q  <= req_col_i;
                  wd_q   <= req_wdata_i;
                  be_q   <= ~req_be_i;
                  act_q  <= 1'b0;
                  if (keep && open_q[req_bank_i] && row_q[req_bank_i] == req_row_i)
                     state_q <= (!req_we_i && cl == 2'h1) ? S_NOP : S_ACC;
                  else if (keep && open_q[req_bank_i])
                     state_q <= S_PRE;
                  else
                     state_q <= S_ACT;
               end
            end
            S_PRE: begin
               cmd_o   <= `CMD_PRE;
               ba_o    <= bank_q;
               a_o     <= 13'h0000;
               open_q[bank_q] <= 1'b0;
               cnt_q   <= trp;
               state_q <= S_PWAIT;
            end
            S_PWAIT: begin
               if (cnt_q == `ZERO8) state_q <= S_ACT;
               else cnt_q <= cnt_q - `ONE8;
            end
            S_ACT: begin
               cmd_o   <= `CMD_ACT;
               ba_o    <= bank_q;
               a_o     <= rrow_q;
               act_q   <= 1'b1;
               state_q <= S_ACC;
            end
            S_NOP: state_q <= S_ACC;
            S_ACC: begin
               cmd_o <= wr_q ? `CMD_WRITE : `CMD_READ;
               ba_o  <= bank_q;
               a_o   <= {2'h0, ~keep, col_q};
               dqm_o <= be_q;
               if (wr_q) begin
                  dq_o      <= wd_q;
                  dq_oe_n_o <= 1'b0;
               end
               if (keep) begin
                  open_q[bank_q] <= 1'b1;
                  row_q[bank_q]  <= rrow_q;
               end
               cnt_q   <= (wr_q && !keep) ? twr + trp : `ZERO8;
               state_q <= S_RECOV;
            end
            S_RECOV: begin
               if (cnt_q == `ZERO8) begin
                  req_done_o <= 1'b1;
                  dqm_o      <= 4'hF;
                  state_q    <= S_IDLE;
               end else
                  cnt_q <= cnt_q - `ONE8;
            end
            S_PALL: begin
               cmd_o   <= `CMD_PRE;
               a_o     <= 13'h0400;
               open_q  <= 4'h0;
               pend_q  <= match && ren && !refresh_mode_select;
               cnt_q   <= trp;
               state_q <= S_RWAIT;
            end
            S_RWAIT: begin
               if (cnt_q == `ZERO8) begin
                  cmd_o   <= `CMD_REF;
                  cnt_q   <= trc;
                  state_q <= S_REF;
               end else
                  cnt_q <= cnt_q - `ONE8;
            end
            S_REF: begin
               if (cnt_q == `ZERO8) begin
                  if (burst_q != 3'h0) begin
                     burst_q <= burst_q - 3'h1;
                     state_q <= S_PALL;
                  end else
                     state_q <= S_IDLE;
               end else
                  cnt_q <= cnt_q - `ONE8;
            end
            S_SWAIT: begin
               if (cnt_q == `ZERO8) begin
                  cmd_o   <= `CMD_REF;
                  cke_o   <= 1'b0;
                  self_q  <= 1'b1;
                  state_q <= S_SREF;
               end else
                  cnt_q <= cnt_q - `ONE8;
            end
            S_SREF: begin
               cmd_o <= `CMD_NOP;
               if (!refresh_mode_select || !ren) begin
                  cke_o   <= 1'b1;
                  self_q  <= 1'b0;
                  cnt_q   <= trc;
                  state_q <= S_XWAIT;
               end
            end
            S_XWAIT: begin
               if (cnt_q == `ZERO8) state_q <= S_IDLE;
               else cnt_q <= cnt_q - `ONE8;
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end
endmodule

// ---- hw/sdram_ctrl_defs.vh ----
// constants for the sdram open-row and refresh controller
// assumes inclusion by bare name from the design files
`ifndef SDRAM_CTRL_DEFS_VH
`define SDRAM_CTRL_DEFS_VH

// register word indices on the wishbone slave, decoded from adr_i[5:2]
`define ADR_CTRL        4'h0
`define ADR_WAIT        4'h1
`define ADR_RTCTL       4'h2
`define ADR_RCOUNT      4'h3
`define ADR_RCOMP       4'h4
`define ADR_STATUS      4'h5
`define ADR_HI          5
`define ADR_LO          2

// control register fields
`define CTRL_KEEP_ROW   0
`define CTRL_REFRESH_ENABLE_EN    1
`define CTRL_REFRESH_MODE_SELECT      2
`define CTRL_RESET      3'h0

// wait register fields: cas latency, precharge wait, recovery wait, write recovery
`define WAIT_CL_LO      0
`define WAIT_CL_HI      1
`define WAIT_TRP_LO     2
`define WAIT_TRP_HI     3
`define WAIT_TRC_LO     4
`define WAIT_TRC_HI     5
`define WAIT_TWR_LO     6
`define WAIT_TWR_HI     7
`define WAIT_RESET      8'h00

// refresh timer control fields
`define RT_CKS_LO       0
`define RT_CKS_HI       2
`define RT_RRC_LO       3
`define RT_RRC_HI       5

// sdram commands {cs_n, ras_n, cas_n, we_n}
`define CMD_NOP         4'h7
`define CMD_ACT         4'h3
`define CMD_READ        4'h5
`define CMD_WRITE       4'h4
`define CMD_PRE         4'h2
`define CMD_REF         4'h1
`define CMD_DESEL       4'hF

`define ONE8            8'h01
`define ZERO8           8'h00
`define ZERO32          32'h00000000
`define ONE4            4'h1
`define BANKS           4

`endif

// ---- hw/refresh_timer.v ----
// refresh interval counter with a selectable count-clock prescaler
// assumes all inputs come from logic on clk_i
`timescale 1ns/1ps
`include "sdram_ctrl_defs.vh"
module refresh_timer (
   input  wire       clk_i,
   input  wire       rst_i,
   input  wire [2:0] cks_i,
   input  wire       load_i,
   input  wire [7:0] load_val_i,
   input  wire [7:0] compare_i,
   output reg  [7:0] count_o,
   output reg        match_o
);
   reg [11:0] pre_q;
   reg        tick;

   // ==========================================================
   // prescaler: cks 0 stops counting, others divide by 4^(cks-1)
   always @(posedge clk_i) begin
      if (rst_i)
         pre_q <= 12'h000;
      else
         pre_q <= pre_q + 12'h001;
   end

   always @* begin
      case (cks_i)
         3'h0:    tick = 1'b0;
         3'h1:    tick = 1'b1;
         3'h2:    tick = (pre_q[1:0] == 2'h3);
         3'h3:    tick = (pre_q[3:0] == 4'hF);
         3'h4:    tick = (pre_q[5:0] == 6'h3F);
         3'h5:    tick = (pre_q[7:0] == 8'hFF);
         3'h6:    tick = (pre_q[9:0] == 10'h3FF);
         default: tick = (pre_q == 12'hFFF);
      endcase
   end

   // ==========================================================
   // counter counts on from its current value; clears on match
   always @(posedge clk_i) begin
      if (rst_i) begin
         count_o <= `ZERO8;
         match_o <= 1'b0;
      end else begin
         match_o <= 1'b0;
         if (load_i)
            count_o <= load_val_i;
         else if (tick) begin
            if (count_o == compare_i) begin
               count_o <= `ZERO8;
               match_o <= 1'b1;
            end else
               count_o <= count_o + `ONE8;
         end
      end
   end
endmodule

// ---- tb/sdram_model.sv ----
// behavioural sdram rank watching the controller pins, tracking open banks
// assumes commands sampled on the controller clock, one rank, four banks
`timescale 1ns/1ps
`include "sdram_ctrl_defs.vh"
module sdram_model (
   input  wire         clk_i,
   input  wire         bus_released_i,
   input  wire  [3:0]  cmd_i,
   input  wire         cke_i,
   input  wire  [1:0]  ba_i,
   input  wire  [12:0] a_i,
   input  wire  [3:0]  dqm_i,
   input  wire  [31:0] dq_i,
   input  wire         dq_oe_n_i,
   output int          n_act,
   output int          n_ref,
   output int          n_err,
   output logic [31:0] wr_dq,
   output logic [3:0]  wr_dqm,
   output logic        wr_ap
);
   logic [3:0] open_q = 4'h0;
   // ====
   // bank state
   always @(posedge clk_i) begin
      // another master leaves every bank precharged
      if (bus_released_i) begin
         open_q <= 4'h0;
      end else begin
         case (cmd_i)
            `CMD_ACT: begin
               if (open_q[ba_i]) n_err <= n_err + 1;
               open_q[ba_i] <= 1'h1;
               n_act <= n_act + 1;
            end
            `CMD_READ, `CMD_WRITE: begin
               if (!open_q[ba_i]) n_err <= n_err + 1;
               if (a_i[10]) open_q[ba_i] <= 1'h0;
               if (cmd_i == `CMD_WRITE) begin
                  if (dq_oe_n_i) n_err <= n_err + 1;
                  wr_dq <= dq_i;
                  wr_dqm <= dqm_i;
                  wr_ap <= a_i[10];
               end
            end
            `CMD_PRE: begin
               if (a_i[10]) open_q <= 4'h0;
               else open_q[ba_i] <= 1'h0;
            end
            `CMD_REF: begin
               if (open_q != 4'h0) n_err <= n_err + 1;
               if (cke_i) n_ref <= n_ref + 1;
            end
            default: ;
         endcase
      end
   end
endmodule

// ---- tb/sdram_ctrl_asserts.sv ----
// port checker for the sdram open-row and refresh controller
// assumes it is bound onto the controller top module
`timescale 1ns/1ps
`include "sdram_ctrl_defs.vh"
module sdram_ctrl_asserts (
   input wire        clk_i,
   input wire        rst_i,
   input wire        cyc_i,
   input wire        stb_i,
   input wire        ack_o,
   input wire        req_i,
   input wire        req_ready_o,
   input wire        req_done_o,
   input wire [3:0]  cmd_o,
   input wire        cke_o,
   input wire [12:0] a_o,
   input wire        dq_oe_n_o
);
   wire pre_all = (cmd_o == `CMD_PRE) && a_o[10];
   wire is_ref = (cmd_o == `CMD_REF);
   wire rw = (cmd_o == `CMD_READ) || (cmd_o == `CMD_WRITE);
   wire access = rw || (cmd_o == `CMD_ACT);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ====
   // properties
   chk_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack held too long");
   chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("bus cycle not answered");
   chk_reset_idle: assert property ($past(rst_i) |-> cmd_o == `CMD_DESEL && cke_o)
      else $error("pins not idle after reset");
   chk_write_drives: assert property (cmd_o == `CMD_WRITE |-> !dq_oe_n_o)
      else $error("write without data drive");
   chk_pre_before_ref: assert property (is_ref && !$past(is_ref) |->
      $past(pre_all) || $past(pre_all, 2) || $past(pre_all, 3) || $past(pre_all, 4))
      else $error("refresh without precharge all");
   chk_self_quiet: assert property (!cke_o |-> !access && !req_ready_o)
      else $error("activity in self refresh");
   chk_act_access: assert property (cmd_o == `CMD_ACT |-> ##[1:8] rw)
      else $error("activate not followed by access");
   chk_ref_recover: assert property (is_ref && cke_o |=> !access)
      else $error("command right after refresh");
   chk_done_pulse: assert property (req_done_o |=> !req_done_o)
      else $error("done held too long");
   chk_take_busy: assert property (req_i && req_ready_o |=> !req_ready_o)
      else $error("ready while access runs");
endmodule
bind sdram_open_row_and_refresh_ctrl sdram_ctrl_asserts u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
   .req_i(req_i), .req_ready_o(req_ready_o), .req_done_o(req_done_o),
   .cmd_o(cmd_o), .cke_o(cke_o), .a_o(a_o), .dq_oe_n_o(dq_oe_n_o));

// ---- tb/test_sdram_open_row_and_refresh_ctrl.sv ----
// self-checking bench: wishbone register master, memory requester, sdram model
// assumes the design header is on the include path
`timescale 1ns/1ps
`include "sdram_ctrl_defs.vh"
module test_sdram_open_row_and_refresh_ctrl;
   logic        clk_i = 1'h0;
   logic        rst_i = 1'h1;
   logic        manual_rst_i = 1'h0;
   logic        cyc_i = 1'h0;
   logic        stb_i = 1'h0;
   logic        we_i = 1'h0;
   logic [5:0]  adr_i = 6'h00;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic        req_i = 1'h0;
   logic        req_we_i = 1'h0;
   logic [1:0]  req_bank_i = 2'h0;
   logic [12:0] req_row_i = 13'h0;
   logic [9:0]  req_col_i = 10'h0;
   logic [31:0] req_wdata_i = 32'h0;
   logic [3:0]  req_be_i = 4'h0;
   logic        bus_released_i = 1'h0;
   wire  [31:0] dat_o, dq_o;
   wire  [12:0] a_o;
   wire  [3:0]  cmd_o, dqm_o;
   wire  [1:0]  ba_o;
   wire         ack_o, req_ready_o, req_done_o, cke_o, dq_oe_n_o;
   int          n_act, n_ref, n_err, seed_v, d, r0;
   int          fail_count = 0;
   int          tests_run = 0;
   logic [31:0] wr_dq, q, q2;
   logic [3:0]  wr_dqm;
   logic        wr_ap;
   logic [1:0]  b;
   logic [12:0] r;
   sdram_open_row_and_refresh_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i),
      .manual_rst_i(manual_rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .req_i(req_i), .req_we_i(req_we_i), .req_bank_i(req_bank_i), .req_row_i(req_row_i),
      .req_col_i(req_col_i), .req_wdata_i(req_wdata_i), .req_be_i(req_be_i),
      .bus_released_i(bus_released_i), .req_ready_o(req_ready_o), .req_done_o(req_done_o),
      .cmd_o(cmd_o), .cke_o(cke_o), .ba_o(ba_o), .a_o(a_o), .dqm_o(dqm_o), .dq_o(dq_o),
      .dq_oe_n_o(dq_oe_n_o));
   sdram_model i_mem (.clk_i(clk_i), .bus_released_i(bus_released_i), .cmd_i(cmd_o),
      .cke_i(cke_o), .ba_i(ba_o), .a_i(a_o), .dqm_i(dqm_o), .dq_i(dq_o),
      .dq_oe_n_i(dq_oe_n_o), .n_act(n_act), .n_ref(n_ref), .n_err(n_err),
      .wr_dq(wr_dq), .wr_dqm(wr_dqm), .wr_ap(wr_ap));
   initial forever #10 clk_i = ~clk_i;
   initial begin
      #200000;
      fail_count++;
      end_of_test();
   end
   // ====
   // tasks
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wb(input logic w, input logic [5:0] ad, input logic [31:0] dw,
                     output logic [31:0] qr);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'h1;
      stb_i <= 1'h1;
      we_i <= w;
      adr_i <= ad;
      sel_i <= 4'hF;
      dat_i <= dw;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'h1 && n < 50);
      if (n >= 50) fail_count++;
      qr = dat_o;
      cyc_i <= 1'h0;
      stb_i <= 1'h0;
   endtask
   task automatic mem(input logic w, input logic [1:0] bk, input logic [12:0] rw,
                      output int dact);
      int n, a0;
      logic [31:0] dw;
      logic [3:0] be;
      n = 0;
      a0 = n_act;
      dw = $urandom;
      be = 4'($urandom_range(1, 15));
      @(posedge clk_i);
      req_i <= 1'h1;
      req_we_i <= w;
      req_bank_i <= bk;
      req_row_i <= rw;
      req_col_i <= 10'($urandom);
      req_wdata_i <= dw;
      req_be_i <= be;
      do begin
         @(posedge clk_i);
         n++;
      end while (req_ready_o !== 1'h1 && n < 200);
      req_i <= 1'h0;
      do begin
         @(posedge clk_i);
         n++;
      end while (req_done_o !== 1'h1 && n < 400);
      if (n >= 400) fail_count++;
      dact = n_act - a0;
      if (w) chk("wr_dq", wr_dq, dw);
      if (w) chk("wr_dqm", wr_dqm, 4'(~be));
   endtask
   task automatic wait_cke(input logic v);
      int n;
      n = 0;
      while (cke_o !== v && n < 300) begin
         @(posedge clk_i);
         n++;
      end
      chk("cke", cke_o, v);
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ====
   // main sequence
   initial begin
      seed_v = $urandom(75578);
      repeat (16) @(posedge clk_i);
      rst_i <= 1'h0;
      chk("pins", {cmd_o, cke_o, dqm_o, dq_oe_n_o}, {`CMD_DESEL, 1'h1, 4'hF, 1'h1});
      for (int i = 0; i < 5; i++) begin
         wb(1'h0, 6'(i * 4), 32'h0, q);
         chk("reg_rst", q, 32'h0);
      end
      wb(1'h1, 6'h3C, 32'hFFFFFFFF, q);
      wb(1'h0, 6'h3C, 32'h0, q);
      chk("unmapped", q, 32'h0);
      wb(1'h1, 6'h04, 32'h55, q);
      wb(1'h0, 6'h04, 32'h0, q);
      chk("wait_reg", q, 32'h55);
      wb(1'h1, 6'h00, 32'h1, q);
      b = 2'($urandom);
      r = 13'($urandom);
      mem(1'h1, b, r, d);
      chk("act_closed", d, 1);
      chk("no_ap", wr_ap, 1'h0);
      mem(1'h1, b, r, d);
      chk("act_hit_wr", d, 0);
      mem(1'h0, b, r, d);
      chk("act_hit_rd", d, 0);
      mem(1'h1, b, r ^ 13'h1, d);
      chk("act_miss", d, 1);
      bus_released_i <= 1'h1;
      repeat (3) @(posedge clk_i);
      bus_released_i <= 1'h0;
      mem(1'h1, b, r ^ 13'h1, d);
      chk("act_release", d, 1);
      wb(1'h1, 6'h00, 32'h0, q);
      mem(1'h1, b + 2'h1, r, d);
      chk("ap_set", wr_ap, 1'h1);
      mem(1'h1, b + 2'h1, r, d);
      chk("act_ap", d, 1);
      wb(1'h1, 6'h00, 32'h1, q);
      mem(1'h1, b, r, d);
      wb(1'h1, 6'h10, 32'h20, q);
      wb(1'h1, 6'h0C, 32'h0, q);
      wb(1'h1, 6'h00, 32'h3, q);
      r0 = n_ref;
      wb(1'h1, 6'h08, 32'h9, q);
      for (int i = 0; i < 4; i++) mem(1'h1, 2'($urandom), 13'($urandom), d);
      repeat (40) @(posedge clk_i);
      chk("refs", n_ref - r0 >= 2, 1);
      wb(1'h1, 6'h08, 32'h0, q);
      wb(1'h0, 6'h0C, 32'h0, q);
      wb(1'h0, 6'h0C, 32'h0, q2);
      chk("cnt_stop", q2, q);
      wb(1'h1, 6'h0C, 32'h5, q);
      wb(1'h0, 6'h0C, 32'h0, q);
      chk("cnt_load", q, 32'h5);
      mem(1'h1, b, r, d);
      chk("act_after_ref", d, 1);
      wb(1'h1, 6'h08, 32'h9, q);
      wb(1'h1, 6'h00, 32'h7, q);
      wait_cke(1'h0);
      chk("ready_self", req_ready_o, 1'h0);
      manual_rst_i <= 1'h1;
      repeat (4) @(posedge clk_i);
      manual_rst_i <= 1'h0;
      r0 = n_ref;
      repeat (30) @(posedge clk_i);
      chk("cke_manual", cke_o, 1'h0);
      chk("refs_self", n_ref - r0, 0);
      r0 = n_ref;
      wb(1'h1, 6'h00, 32'h3, q);
      wb(1'h1, 6'h0C, 32'h1F, q);
      wait_cke(1'h1);
      repeat (60) @(posedge clk_i);
      chk("refs_resume", n_ref - r0 >= 1, 1);
      wb(1'h1, 6'h10, 32'h1, q);
      wb(1'h1, 6'h0C, 32'h0, q);
      repeat (20) @(posedge clk_i);
      wb(1'h0, 6'h14, 32'h0, q);
      chk("lost", q[8], 1'h1);
      wb(1'h1, 6'h08, 32'h0, q);
      wb(1'h1, 6'h00, 32'h7, q);
      wait_cke(1'h0);
      rst_i <= 1'h1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'h0;
      @(posedge clk_i);
      chk("cke_por", cke_o, 1'h1);
      wb(1'h0, 6'h00, 32'h0, q);
      chk("ctrl_por", q, 32'h0);
      chk("model_err", n_err, 0);
      end_of_test();
   end
endmodule
